// ### core/spirc_params.svh
/*
 spi register control: offsets (register index, byte address = 4 * index),
 field positions, reset values and clock-rate half periods.
 assumes inclusion by core/spirc_top.sv and by the testbench.
*/
`ifndef SPIRC_PARAMS_SVH
`define SPIRC_PARAMS_SVH

// register indexes
`define SPIRC_IDX_PORT_D_DATA 8'h08
`define SPIRC_IDX_PORT_D_DIRECTION 8'h09
`define SPIRC_IDX_SERIAL_CONTROL 8'h28
`define SPIRC_IDX_SERIAL_STATUS 8'h29
`define SPIRC_IDX_SERIAL_DATA 8'h2a
`define SPIRC_IDX_SYSTEM_OPTIONS_TWO 8'h38

// serial_control fields
`define SPIRC_CTL_IRQ_ENABLE 7
`define SPIRC_CTL_SYSTEM_ENABLE 6
`define SPIRC_CTL_OPEN_DRAIN 5
`define SPIRC_CTL_ROLE_SELECT 4
`define SPIRC_CTL_CLOCK_POLARITY 3
`define SPIRC_CTL_CLOCK_PHASE 2
`define SPIRC_CTL_RATE_HI 1
`define SPIRC_CTL_RATE_LO 0

// serial_status fields
`define SPIRC_STS_TRANSFER_COMPLETE 7
`define SPIRC_STS_WRITE_COLLISION 6
`define SPIRC_STS_MODE_FAULT 4

// system_options_two fields
`define SPIRC_OPT_LSB_FIRST 3
`define SPIRC_OPT_RATE_PRESCALE 2

// pin positions inside the 4-bit pin ports (port d bits 5..2)
`define SPIRC_PIN_SELECT 3
`define SPIRC_PIN_SCK 2
`define SPIRC_PIN_MOSI 1
`define SPIRC_PIN_MISO 0

// reset values
`define SPIRC_RST_CONTROL 8'h00
`define SPIRC_RST_DIRECTION 8'h00
`define SPIRC_RST_OPTIONS 8'h00
`define SPIRC_RST_PORT_DATA 8'h00

// sck half periods in e clocks, per {prescale, control rate bits 1..0}
`define SPIRC_HALF_000 7'h01
`define SPIRC_HALF_001 7'h02
`define SPIRC_HALF_010 7'h08
`define SPIRC_HALF_011 7'h10
`define SPIRC_HALF_100 7'h04
`define SPIRC_HALF_101 7'h08
`define SPIRC_HALF_110 7'h20
`define SPIRC_HALF_111 7'h40

// last sck edge index and last bit index of one byte
`define SPIRC_LAST_EDGE 4'hf
`define SPIRC_LAST_BIT 3'h7

`endif

// ### core/spirc_pkg.sv
/*
 spi register control: shared types.
 assumes nothing beyond a systemverilog compiler.
*/
package spirc_pkg;
   typedef enum logic {SPIRC_IDLE, SPIRC_RUN} spirc_state_e;
endpackage

// ### core/spirc_top.sv
/*
 spi register control: apb register slave, master clock generator, shift engine,
 port d pin control for the four spi pins.
 assumes apb master on clk, pins asynchronous to clk, external tri-state pads.
*/
// Chosen here: the APB register port.
`timescale 1ns/1ns
`include "spirc_params.svh"

module spirc_top (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [9:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [3:0] pd_in,
   output logic [3:0] pd_out,
   output logic [3:0] pd_oe_n,
   output logic spi_irq
);
   logic [7:0] ctrl_ff, ddr_ff, opt_ff, pdat_ff, rxbuf_ff, shreg_ff;
   logic [31:0] prdata_ff;
   logic pready_ff, pslverr_ff, irq_ff;
   logic transfer_complete_flag_ff, write_collision_flag_ff, mode_fault_flag_ff, transfer_complete_flag_arm_ff, write_collision_flag_arm_ff, mode_fault_flag_arm_ff;
   logic [3:0] sync1_ff, sync2_ff, pd_out_ff, pd_oe_n_ff, nxt_pd_out, nxt_pd_oe_n;
   logic sck_d_ff, sck_ff, tx_bit_ff, s_busy_ff;
   logic [6:0] div_cnt_ff, half;
   logic [3:0] edge_ff;
   logic [2:0] bcnt_ff;
   spirc_pkg::spirc_state_e state_ff;
   logic [7:0] idx;
   logic acc, wr, rd, hit, data_wr, data_acc, ctrl_wr, wr_ok, start, write_collision_flag_evt;
   logic system_enable, role_select, clock_polarity, clock_phase, lsb_first_enable, ss_low, mfault, in_bit;
   logic m_tick, m_sample, m_last, s_active, s_edge, s_lead, s_sample, s_shift;
   logic sample, done_evt, busy;

   function automatic logic out_bit(input logic [7:0] v, input logic lsb);
      out_bit = lsb ? v[0] : v[7];
   endfunction

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign pd_out = pd_out_ff;
   assign pd_oe_n = pd_oe_n_ff;
   assign spi_irq = irq_ff;

   // bus decode
   assign idx = paddr[9:2];
   assign acc = psel && penable && pready_ff;
   assign wr = acc && pwrite;
   assign rd = acc && !pwrite;
   assign hit = (idx == `SPIRC_IDX_PORT_D_DATA) || (idx == `SPIRC_IDX_PORT_D_DIRECTION) ||
                (idx == `SPIRC_IDX_SERIAL_CONTROL) || (idx == `SPIRC_IDX_SERIAL_STATUS) ||
                (idx == `SPIRC_IDX_SERIAL_DATA) || (idx == `SPIRC_IDX_SYSTEM_OPTIONS_TWO);
   assign data_acc = acc && (idx == `SPIRC_IDX_SERIAL_DATA);
   assign data_wr = data_acc && pwrite;
   assign ctrl_wr = wr && (idx == `SPIRC_IDX_SERIAL_CONTROL);

   assign system_enable = ctrl_ff[`SPIRC_CTL_SYSTEM_ENABLE];
   assign role_select = ctrl_ff[`SPIRC_CTL_ROLE_SELECT];
   assign clock_polarity = ctrl_ff[`SPIRC_CTL_CLOCK_POLARITY];
   assign clock_phase = ctrl_ff[`SPIRC_CTL_CLOCK_PHASE];
   assign lsb_first_enable = opt_ff[`SPIRC_OPT_LSB_FIRST];
   assign ss_low = !sync2_ff[`SPIRC_PIN_SELECT];

   // fault only when select pin is an spi input
   assign mfault = system_enable && role_select && !ddr_ff[5] && ss_low;
   assign busy = role_select ? (state_ff == spirc_pkg::SPIRC_RUN) :
                 (clock_phase ? s_busy_ff : (system_enable && ss_low));
   assign wr_ok = !(transfer_complete_flag_ff && !transfer_complete_flag_arm_ff);
   assign write_collision_flag_evt = data_wr && wr_ok && system_enable && busy;
   assign start = data_wr && wr_ok && system_enable && role_select && !busy && !mfault;

   // rate selection
   always_comb begin
      case ({opt_ff[`SPIRC_OPT_RATE_PRESCALE], ctrl_ff[1:0]})
         3'h0: half = `SPIRC_HALF_000;
         3'h1: half = `SPIRC_HALF_001;
         3'h2: half = `SPIRC_HALF_010;
         3'h3: half = `SPIRC_HALF_011;
         3'h4: half = `SPIRC_HALF_100;
         3'h5: half = `SPIRC_HALF_101;
         3'h6: half = `SPIRC_HALF_110;
         default: half = `SPIRC_HALF_111;
      endcase
   end

   // shift timing, master and slave
   assign m_tick = (state_ff == spirc_pkg::SPIRC_RUN) && (div_cnt_ff == half - 7'h01);
   assign m_sample = m_tick && (edge_ff[0] == clock_phase);
   assign m_last = m_tick && (edge_ff == `SPIRC_LAST_EDGE);
   assign s_active = system_enable && !role_select && ss_low;
   assign s_edge = s_active && (sync2_ff[`SPIRC_PIN_SCK] != sck_d_ff);
   assign s_lead = sync2_ff[`SPIRC_PIN_SCK] != clock_polarity;
   assign s_sample = s_edge && (s_lead != clock_phase);
   assign s_shift = s_edge && (s_lead == clock_phase);
   assign sample = role_select ? m_sample : s_sample;
   assign in_bit = role_select ? sync2_ff[`SPIRC_PIN_MISO] : sync2_ff[`SPIRC_PIN_MOSI];
   assign done_evt = role_select ? m_last : (s_sample && (bcnt_ff == `SPIRC_LAST_BIT));

   // pin input synchroniser
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sync1_ff <= 4'hf;
         sync2_ff <= 4'hf;
         sck_d_ff <= 1'b0;
      end else begin
         sync1_ff <= pd_in;
         sync2_ff <= sync1_ff;
         sck_d_ff <= sync2_ff[`SPIRC_PIN_SCK];
      end
   end

   // apb answer, one wait state
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h0;
      end else begin
         pready_ff <= psel && penable && !pready_ff;
         pslverr_ff <= psel && penable && !pready_ff && !hit;
         prdata_ff <= 32'h0;
         if (psel && penable && !pready_ff && !pwrite) begin
            case (idx)
               `SPIRC_IDX_PORT_D_DATA: prdata_ff <= {24'h0, pdat_ff};
               `SPIRC_IDX_PORT_D_DIRECTION: prdata_ff <= {24'h0, ddr_ff};
               `SPIRC_IDX_SERIAL_CONTROL: prdata_ff <= {24'h0, ctrl_ff};
               `SPIRC_IDX_SERIAL_STATUS: prdata_ff <= {24'h0, transfer_complete_flag_ff, write_collision_flag_ff, 1'b0,
                                                       mode_fault_flag_ff, 4'h0};
               `SPIRC_IDX_SERIAL_DATA: prdata_ff <= {24'h0, rxbuf_ff};
               `SPIRC_IDX_SYSTEM_OPTIONS_TWO: prdata_ff <= {24'h0, opt_ff};
               default: prdata_ff <= 32'h0;
            endcase
         end
      end
   end

   // control, direction, options, port data
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrl_ff <= `SPIRC_RST_CONTROL;
         ddr_ff <= `SPIRC_RST_DIRECTION;
         opt_ff <= `SPIRC_RST_OPTIONS;
         pdat_ff <= `SPIRC_RST_PORT_DATA;
      end else begin
         if (ctrl_wr)
            ctrl_ff <= pwdata[7:0];
         if (wr && idx == `SPIRC_IDX_PORT_D_DIRECTION)
            ddr_ff <= pwdata[7:0];
         if (wr && idx == `SPIRC_IDX_SYSTEM_OPTIONS_TWO)
            opt_ff <= pwdata[7:0];
         if (wr && idx == `SPIRC_IDX_PORT_D_DATA)
            pdat_ff <= pwdata[7:0];
         if (mfault) begin
            ctrl_ff[`SPIRC_CTL_ROLE_SELECT] <= 1'b0;
            ddr_ff[5:2] <= 4'h0;
         end
      end
   end

   // status flags, set wins over clear
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         transfer_complete_flag_ff <= 1'b0;
         write_collision_flag_ff <= 1'b0;
         mode_fault_flag_ff <= 1'b0;
         transfer_complete_flag_arm_ff <= 1'b0;
         write_collision_flag_arm_ff <= 1'b0;
         mode_fault_flag_arm_ff <= 1'b0;
      end else begin
         if (rd && idx == `SPIRC_IDX_SERIAL_STATUS) begin
            transfer_complete_flag_arm_ff <= prdata_ff[`SPIRC_STS_TRANSFER_COMPLETE];
            write_collision_flag_arm_ff <= prdata_ff[`SPIRC_STS_WRITE_COLLISION];
            mode_fault_flag_arm_ff <= prdata_ff[`SPIRC_STS_MODE_FAULT];
         end
         if (data_acc && transfer_complete_flag_arm_ff) begin
            transfer_complete_flag_ff <= 1'b0;
            transfer_complete_flag_arm_ff <= 1'b0;
         end
         if (data_acc && write_collision_flag_arm_ff) begin
            write_collision_flag_ff <= 1'b0;
            write_collision_flag_arm_ff <= 1'b0;
         end
         if (ctrl_wr && mode_fault_flag_arm_ff) begin
            mode_fault_flag_ff <= 1'b0;
            mode_fault_flag_arm_ff <= 1'b0;
         end
         if (done_evt)
            transfer_complete_flag_ff <= 1'b1;
         if (write_collision_flag_evt)
            write_collision_flag_ff <= 1'b1;
         if (mfault)
            mode_fault_flag_ff <= 1'b1;
      end
   end

   // interrupt request level
   always_ff @(posedge clk) begin
      if (!rst_n)
         irq_ff <= 1'b0;
      else
         irq_ff <= ctrl_ff[`SPIRC_CTL_IRQ_ENABLE] && (transfer_complete_flag_ff || mode_fault_flag_ff);
   end

   // master clock generator
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_ff <= spirc_pkg::SPIRC_IDLE;
         div_cnt_ff <= 7'h0;
         edge_ff <= 4'h0;
         sck_ff <= 1'b0;
      end else begin
         case (state_ff)
            spirc_pkg::SPIRC_IDLE: begin
               sck_ff <= clock_polarity;
               div_cnt_ff <= 7'h0;
               edge_ff <= 4'h0;
               if (start)
                  state_ff <= spirc_pkg::SPIRC_RUN;
            end
            spirc_pkg::SPIRC_RUN: begin
               if (mfault || !system_enable || !role_select) begin
                  state_ff <= spirc_pkg::SPIRC_IDLE;
               end else if (m_tick) begin
                  div_cnt_ff <= 7'h0;
                  sck_ff <= !sck_ff;
                  edge_ff <= edge_ff + 4'h1;
                  if (m_last)
                     state_ff <= spirc_pkg::SPIRC_IDLE;
               end else begin
                  div_cnt_ff <= div_cnt_ff + 7'h01;
               end
            end
            default: state_ff <= spirc_pkg::SPIRC_IDLE;
         endcase
      end
   end

   // shifter, bit counter, receive buffer
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         shreg_ff <= 8'h0;
         tx_bit_ff <= 1'b0;
         bcnt_ff <= 3'h0;
         rxbuf_ff <= 8'h0;
         s_busy_ff <= 1'b0;
      end else begin
         if (data_wr && wr_ok && !busy) begin
            shreg_ff <= pwdata[7:0];
            tx_bit_ff <= out_bit(pwdata[7:0], lsb_first_enable);
            bcnt_ff <= 3'h0;
         end else if (sample) begin
            shreg_ff <= lsb_first_enable ? {in_bit, shreg_ff[7:1]} : {shreg_ff[6:0], in_bit};
            bcnt_ff <= bcnt_ff + 3'h1;
         end else if ((role_select && m_tick) || (!role_select && s_shift)) begin
            tx_bit_ff <= out_bit(shreg_ff, lsb_first_enable);
         end else if (!role_select && !s_active) begin
            bcnt_ff <= 3'h0;
         end
         // byte lost when the previous one is still unread
         if (done_evt && !transfer_complete_flag_ff)
            rxbuf_ff <= sample ? (lsb_first_enable ? {in_bit, shreg_ff[7:1]} :
                                  {shreg_ff[6:0], in_bit}) : shreg_ff;
         if (!s_active || (s_sample && bcnt_ff == `SPIRC_LAST_BIT))
            s_busy_ff <= 1'b0;
         else if (s_edge)
            s_busy_ff <= 1'b1;
      end
   end

   // pin drive, open drain releases a high
   always_comb begin
      logic [3:0] drv, val;
      drv = ddr_ff[5:2];
      val = pdat_ff[5:2];
      if (system_enable) begin
         if (role_select) begin
            drv[`SPIRC_PIN_SELECT] = ddr_ff[5];
            val[`SPIRC_PIN_SCK] = sck_ff;
            val[`SPIRC_PIN_MOSI] = tx_bit_ff;
            drv[`SPIRC_PIN_MISO] = 1'b0;
         end else begin
            drv[`SPIRC_PIN_SELECT] = 1'b0;
            drv[`SPIRC_PIN_SCK] = 1'b0;
            drv[`SPIRC_PIN_MOSI] = 1'b0;
            drv[`SPIRC_PIN_MISO] = ddr_ff[2] && ss_low;
            val[`SPIRC_PIN_MISO] = tx_bit_ff;
         end
      end
      nxt_pd_out = val;
      nxt_pd_oe_n = ~(drv & ~({4{ctrl_ff[`SPIRC_CTL_OPEN_DRAIN]}} & val));
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pd_out_ff <= 4'h0;
         pd_oe_n_ff <= 4'hf;
      end else begin
         pd_out_ff <= nxt_pd_out;
         pd_oe_n_ff <= nxt_pd_oe_n;
      end
   end

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_irq;
      ##1 spi_irq == $past(ctrl_ff[7] && (transfer_complete_flag_ff || mode_fault_flag_ff));
   endproperty
   a_irq: assert property (p_irq) else $error("irq level mismatch");

   property p_sck_idle;
      (state_ff == spirc_pkg::SPIRC_IDLE) ##1 (state_ff == spirc_pkg::SPIRC_IDLE)
         |-> sck_ff == $past(clock_polarity);
   endproperty
   a_sck_idle: assert property (p_sck_idle) else $error("idle sck wrong");

   property p_mode_fault_flag;
      mfault |=> mode_fault_flag_ff && !ctrl_ff[4] && (ddr_ff[5:2] == 4'h0);
   endproperty
   a_mode_fault_flag: assert property (p_mode_fault_flag) else $error("mode fault not taken");

   property p_write_collision_flag;
      (data_wr && wr_ok && system_enable && busy) |=> write_collision_flag_ff;
   endproperty
   a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision not flagged");

   property p_ignore;
      (data_wr && transfer_complete_flag_ff && !transfer_complete_flag_arm_ff && state_ff == spirc_pkg::SPIRC_IDLE)
         |=> state_ff == spirc_pkg::SPIRC_IDLE && !write_collision_flag_evt;
   endproperty
   a_ignore: assert property (p_ignore) else $error("gated write started");

   property p_start;
      start |=> state_ff == spirc_pkg::SPIRC_RUN && sck_ff == clock_polarity;
   endproperty
   a_start: assert property (p_start) else $error("master did not start");

   property p_transfer_complete_flag_hold;
      (transfer_complete_flag_ff && !(data_acc && transfer_complete_flag_arm_ff)) |=> transfer_complete_flag_ff;
   endproperty
   a_transfer_complete_flag_hold: assert property (p_transfer_complete_flag_hold) else $error("flag cleared early");

   property p_mode_fault_flag_hold;
      (mode_fault_flag_ff && !(ctrl_wr && mode_fault_flag_arm_ff)) |=> mode_fault_flag_ff;
   endproperty
   a_mode_fault_flag_hold: assert property (p_mode_fault_flag_hold) else $error("fault cleared early");

   property p_slave_nostart;
      (data_wr && !role_select) |=> state_ff == spirc_pkg::SPIRC_IDLE;
   endproperty
   a_slave_nostart: assert property (p_slave_nostart) else $error("slave clocked");

   c_master_done: cover property (role_select && m_last);
   c_slave_done: cover property (!role_select && done_evt);
   c_fault: cover property (mfault);
   c_collision: cover property (write_collision_flag_evt);
endmodule

// ### dv/spirc_slave_model.sv
/*
 spi slave model standing on the far side of the port d spi pins.
 assumes mode bits matching the master and a select line driven by the bench.
*/
`timescale 1ns/1ns
module spirc_slave_model (
   input wire logic sck,
   input wire logic mosi,
   input wire logic ss_n,
   input wire logic clock_polarity,
   input wire logic clock_phase,
   input wire logic [7:0] tx,
   output logic miso,
   output logic [7:0] rx
);
   logic [7:0] sh;
   logic drv;
   initial begin
      sh = 8'h00;
      drv = 1'b0;
      rx = 8'h00;
   end
   // load at select, phase 0 shows the first bit at once
   always @(negedge ss_n) begin
      sh = clock_phase ? tx : {tx[6:0], 1'b0};
      drv = clock_phase ? drv : tx[7];
   end
   // sample on leading edge for phase 0, on trailing edge for phase 1
   always @(sck) begin
      if (!ss_n && sck == (clock_polarity == clock_phase)) begin
         rx = {rx[6:0], mosi};
      end else if (!ss_n) begin
         drv = sh[7];
         sh = {sh[6:0], 1'b0};
      end
   end
   // released line shows the inverse of the last bit
   assign miso = ss_n ? ~drv : drv;
endmodule

// ### dv/test_spi_register_control.sv
/*
 testbench for spirc_top: apb register access and master transfers to a slave model.
 assumes design files and dv/spirc_slave_model.sv compiled first; pull-ups on the pins.
*/
`timescale 1ns/1ns
`include "spirc_params.svh"
module test_spi_register_control;
   typedef struct packed {
      logic [7:0] ctl;
      logic [7:0] opt;
      logic [7:0] tx;
      logic [7:0] stx;
      logic [7:0] div;
      logic rx_ok;
   } spirc_row_s;
   localparam logic [7:0] CTL = `SPIRC_IDX_SERIAL_CONTROL;
   localparam logic [7:0] STS = `SPIRC_IDX_SERIAL_STATUS;
   localparam logic [7:0] DAT = `SPIRC_IDX_SERIAL_DATA;
   localparam logic [7:0] DIR = `SPIRC_IDX_PORT_D_DIRECTION;
   localparam logic [7:0] OPT = `SPIRC_IDX_SYSTEM_OPTIONS_TWO;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [9:0] paddr = 10'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready, pslverr, spi_irq, miso, err, sck_q;
   logic [3:0] pd_out, pd_oe_n, pins;
   logic ss_pin = 1'b1;
   logic mss_n = 1'b1;
   logic [7:0] stx = 8'h00;
   logic [7:0] ctl_now = 8'h00;
   logic [7:0] srx, rd;
   int mismatches = 0;
   int total_checks = 0;
   int cycles = 0;
   int edges = 0;
   int per = 0;
   int cnt = 0;
   spirc_row_s rows [8];

   assign pins[3] = ss_pin;
   assign pins[2] = !pd_oe_n[2] ? pd_out[2] : 1'b1;
   assign pins[1] = !pd_oe_n[1] ? pd_out[1] : 1'b1;
   assign pins[0] = miso;

   spirc_top DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pd_in(pins), .pd_out(pd_out),
      .pd_oe_n(pd_oe_n), .spi_irq(spi_irq));
   spirc_slave_model u_slave (.sck(pins[2]), .mosi(pins[1]), .ss_n(mss_n),
      .clock_polarity(ctl_now[3]), .clock_phase(ctl_now[2]), .tx(stx), .miso(miso), .rx(srx));

   always #50 clk = ~clk;

   // sck rising edge count and period in clocks
   always @(posedge clk) begin
      cycles <= cycles + 1;
      sck_q <= pins[2];
      cnt <= cnt + 1;
      if (pins[2] === 1'b1 && sck_q === 1'b0) begin
         edges <= edges + 1;
         per <= cnt + 1;
         cnt <= 0;
      end
      if (cycles == 20000) begin
         mismatches = mismatches + 1;
         final_report();
      end
   end

   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: %s got %h want %h", $time, m, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp, input string m);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: %s got %b want %b", $time, m, got, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h000000, wd};
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdc(input logic [7:0] idx, input logic [7:0] exp, input string m);
      apb(1'b0, idx, 8'h00);
      chk8(rd, exp, m);
   endtask

   // tail covers the last half period after the 8th rising edge
   task automatic wait_sck(input int tail);
      for (int n = 0; n < 3000 && edges < 8; n++) begin
         @(posedge clk);
      end
      repeat (tail + 6) @(posedge clk);
   endtask

   function automatic logic [7:0] rev8(input logic [7:0] v);
      logic [7:0] r;
      for (int i = 0; i < 8; i++) begin
         r[i] = v[7 - i];
      end
      return r;
   endfunction

   task automatic xfer(input spirc_row_s r);
      apb(1'b1, OPT, r.opt);
      apb(1'b1, DIR, 8'h18);
      apb(1'b1, CTL, r.ctl);
      ctl_now = r.ctl;
      stx <= r.stx;
      // let a polarity change settle before the slave is selected
      repeat (4) @(posedge clk);
      chk1(pins[2], r.ctl[3], "sck idle");
      mss_n <= 1'b0;
      edges = 0;
      apb(1'b1, DAT, r.tx);
      wait_sck(r.div);
      chk8(edges[7:0], 8'h08, "sck count");
      chk8(per[7:0], r.div, "sck period");
      chk8(srx, r.opt[3] ? rev8(r.tx) : r.tx, "slave rx");
      chk1(spi_irq, 1'b1, "irq");
      rdc(STS, 8'h80, "flag set");
      apb(1'b0, DAT, 8'h00);
      if (r.rx_ok) begin
         chk8(rd, r.opt[3] ? rev8(r.stx) : r.stx, "rx buffer");
      end
      rdc(STS, 8'h00, "flag clear");
      chk1(spi_irq, 1'b0, "irq clear");
      mss_n <= 1'b1;
   endtask

   initial begin
      rows[0] = '{8'hd0, 8'h00, 8'ha5, 8'h3c, 8'h02, 1'b0};
      rows[1] = '{8'hd1, 8'h00, 8'h5a, 8'hc3, 8'h04, 1'b0};
      rows[2] = '{8'hd2, 8'h08, 8'h01, 8'h80, 8'h10, 1'b1};
      rows[3] = '{8'hd7, 8'h00, 8'h96, 8'h69, 8'h20, 1'b1};
      rows[4] = '{8'hd0, 8'h04, 8'hf0, 8'h0f, 8'h08, 1'b1};
      rows[5] = '{8'hd5, 8'h04, 8'h81, 8'h7e, 8'h10, 1'b1};
      rows[6] = '{8'hda, 8'h04, 8'h33, 8'hcc, 8'h40, 1'b1};
      rows[7] = '{8'hff, 8'h0c, 8'h12, 8'h48, 8'h80, 1'b1};
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rdc(CTL, 8'h00, "control reset");
      rdc(STS, 8'h00, "status reset");
      rdc(DIR, 8'h00, "direction reset");
      rdc(OPT, 8'h00, "options reset");
      rdc(DAT, 8'h00, "data reset");
      chk8({4'h0, pd_oe_n}, 8'h0f, "pins released");
      apb(1'b1, 8'h30, 8'hff);
      chk1(err, 1'b1, "unmapped");
      apb(1'b1, STS, 8'hff);
      rdc(STS, 8'h00, "status read only");
      $display("reset test done");
      for (int i = 0; i < 8; i++) begin
         xfer(rows[i]);
         $display("row %0d done", i);
      end
      apb(1'b1, OPT, 8'h00);
      apb(1'b1, CTL, 8'hd2);
      ctl_now = 8'hd2;
      mss_n <= 1'b0;
      stx <= 8'h00;
      edges = 0;
      apb(1'b1, DAT, 8'h55);
      apb(1'b1, DAT, 8'haa);
      wait_sck(16);
      apb(1'b1, DAT, 8'h33);
      repeat (40) @(posedge clk);
      chk8(edges[7:0], 8'h08, "blocked writes");
      chk8(srx, 8'h55, "undisturbed");
      rdc(STS, 8'hc0, "collision");
      apb(1'b0, DAT, 8'h00);
      rdc(STS, 8'h00, "collision clear");
      mss_n <= 1'b1;
      $display("collision test done");
      apb(1'b1, CTL, 8'h52);
      edges = 0;
      apb(1'b1, DAT, 8'h0f);
      wait_sck(16);
      chk1(spi_irq, 1'b0, "irq masked");
      rdc(STS, 8'h80, "masked flag");
      apb(1'b0, DAT, 8'h00);
      $display("mask test done");
      apb(1'b1, CTL, 8'hd2);
      ss_pin <= 1'b0;
      repeat (6) @(posedge clk);
      chk1(spi_irq, 1'b1, "fault irq");
      ss_pin <= 1'b1;
      rdc(CTL, 8'hc2, "role cleared");
      rdc(DIR, 8'h00, "directions cleared");
      rdc(STS, 8'h10, "fault flag");
      apb(1'b1, CTL, 8'hd2);
      rdc(STS, 8'h00, "fault clear");
      $display("fault test done");
      apb(1'b1, CTL, 8'h40);
      ss_pin <= 1'b0;
      repeat (4) @(posedge clk);
      edges = 0;
      apb(1'b1, DAT, 8'h77);
      repeat (20) @(posedge clk);
      chk8(edges[7:0], 8'h00, "slave no clock");
      rdc(STS, 8'h40, "slave collision");
      apb(1'b0, DAT, 8'h00);
      rdc(STS, 8'h00, "slave collision clear");
      ss_pin <= 1'b1;
      $display("slave test done");
      final_report();
   end
endmodule
